// ===== common/pbsc_pkg.sv
// Package for the pipelined burst memory control block.
// Holds the widths, reset values and the access carrier that the control uses.
package pbsc_pkg;
   // Array geometry
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CHECK_W = 2;
   localparam int LANES = 2;
   localparam int LANE_W = 8;
   localparam int WORD_W = DATA_W + CHECK_W;
   localparam int BURST_W = 2;

   // Burst order strap levels; interleaved is the floating default
   localparam logic ORDER_LINEAR = 1'h0;
   localparam logic ORDER_INTERLEAVED = 1'h1;

   // Reset values
   localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
   localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
   localparam logic [LANES-1:0] LANES_OFF_N = 2'h3;

   // One access as it moves down the pipeline
   typedef struct packed {
      logic valid;
      logic write;
      logic [LANES-1:0] lane_write_n;
      logic [ADDR_W-1:0] addr;
   } pbsc_access_t;

   localparam pbsc_access_t ACCESS_IDLE = '{valid: 1'b0, write: 1'b0, lane_write_n: LANES_OFF_N, addr: ADDR_RESET};
endpackage : pbsc_pkg

// ===== hdl/pbsc_control.sv
// Control of a synchronous pipelined burst static memory with a common data bus.
// Assumes the storage array outside answers array_rd_data combinationally from array_rd_addr
// and performs a write on each cycle that array_wr_en is high; all pins but output enable and sleep are synchronous to ref_clk.
module pbsc_control (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Synchronous access controls
   input wire logic [pbsc_pkg::ADDR_W-1:0] addr_in,
   input wire logic burst_step_or_load,
   input wire logic clock_qualify_n,
   input wire logic chip_select_low_first,
   input wire logic chip_select_high_second,
   input wire logic chip_select_low_third,
   input wire logic write_n,
   input wire logic [pbsc_pkg::LANES-1:0] byte_lane_write_n,
   // Asynchronous controls and strap
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_strap,
   // Data and check-bit lines, split into in, out and enable
   input wire logic [pbsc_pkg::DATA_W-1:0] data_lines_in,
   output logic [pbsc_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe,
   input wire logic [pbsc_pkg::CHECK_W-1:0] check_bit_lines_in,
   output logic [pbsc_pkg::CHECK_W-1:0] check_bit_lines_out,
   output logic check_bit_lines_oe,
   // Storage array side
   output logic [pbsc_pkg::ADDR_W-1:0] array_rd_addr,
   input wire logic [pbsc_pkg::WORD_W-1:0] array_rd_data,
   output logic array_wr_en,
   output logic [pbsc_pkg::ADDR_W-1:0] array_wr_addr,
   output logic [pbsc_pkg::WORD_W-1:0] array_wr_data,
   output logic [pbsc_pkg::LANES-1:0] array_wr_lane,
   output logic array_sleep
);

   // Burst position from start bits and count, used for stepping and checking
   function automatic logic [pbsc_pkg::BURST_W-1:0] pbsc_burst_pos(
      input logic order,
      input logic [pbsc_pkg::BURST_W-1:0] start,
      input logic [pbsc_pkg::BURST_W-1:0] count
   );
      if (order == pbsc_pkg::ORDER_LINEAR)
      begin
         return start + count;
      end
      return start ^ count;
   endfunction : pbsc_burst_pos

   pbsc_pkg::pbsc_access_t addr_stage;
   pbsc_pkg::pbsc_access_t data_stage;
   pbsc_pkg::pbsc_access_t next_addr_stage;
   logic [pbsc_pkg::BURST_W-1:0] burst_start;
   logic [pbsc_pkg::BURST_W-1:0] burst_count;
   logic [pbsc_pkg::BURST_W-1:0] next_count;
   logic burst_order;
   logic [pbsc_pkg::WORD_W-1:0] read_word;
   logic read_drive;
   wire logic edge_ok;
   wire logic selected_now;
   wire logic load_now;
   wire logic step_now;
   wire logic drive_allowed;

   // qualified edge; sleep also freezes the pipeline so contents stay intact
   assign edge_ok = !clock_qualify_n && !sleep_request;
   assign selected_now = !chip_select_low_first && chip_select_high_second && !chip_select_low_third;
   assign load_now = edge_ok && !burst_step_or_load;
   assign step_now = edge_ok && burst_step_or_load;
   assign next_count = burst_count + 2'h1;

   // Next address stage: load takes pins, step keeps select and type and moves low bits
   always_comb
   begin
      next_addr_stage = addr_stage;
      next_addr_stage.lane_write_n = byte_lane_write_n;
      if (!burst_step_or_load)
      begin
         next_addr_stage.valid = selected_now;
         next_addr_stage.write = !write_n;
         next_addr_stage.addr = addr_in;
      end
      else
      begin
         // only the two low bits wrap
         next_addr_stage.addr[pbsc_pkg::BURST_W-1:0] = pbsc_burst_pos(burst_order, burst_start, next_count);
      end
   end

   // Address register and burst counter
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_stage <= pbsc_pkg::ACCESS_IDLE;
         burst_start <= pbsc_pkg::COUNT_RESET;
         burst_count <= pbsc_pkg::COUNT_RESET;
      end
      // inputs captured only on recognized edges; else hold
      else if (edge_ok)
      begin
         addr_stage <= next_addr_stage;
         if (load_now)
         begin
            burst_start <= addr_in[pbsc_pkg::BURST_W-1:0];
            burst_count <= pbsc_pkg::COUNT_RESET;
         end
         else
         begin
            // step burst counter; type kept from load
            burst_count <= next_count;
         end
      end
   end

   // Strap follows its pin every cycle; interleaved until the first edge after reset
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         burst_order <= pbsc_pkg::ORDER_INTERLEAVED;
      end
      else
      begin
         burst_order <= burst_order_strap;
      end
   end

   // Data phase stage and output register; a stall holds them like the address register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_stage <= pbsc_pkg::ACCESS_IDLE;
         read_word <= pbsc_pkg::WORD_RESET;
         read_drive <= 1'b0;
      end
      else if (edge_ok)
      begin
         data_stage <= addr_stage;
         // word of the address taken at the read's own edge
         read_word <= array_rd_data;
         // deselect or write turns drivers off after the next edge
         read_drive <= addr_stage.valid && !addr_stage.write;
      end
   end

   // Write completion: data taken two recognized edges after the address edge
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         array_wr_en <= 1'b0;
         array_wr_addr <= pbsc_pkg::ADDR_RESET;
         array_wr_data <= pbsc_pkg::WORD_RESET;
         array_wr_lane <= '0;
      end
      else
      begin
         // one strobe per completed write, none while stalled
         array_wr_en <= edge_ok && data_stage.valid && data_stage.write;
         if (edge_ok)
         begin
            // input lines into the write data register
            array_wr_data <= {check_bit_lines_in, data_lines_in};
            array_wr_addr <= data_stage.addr;
            // lane enables gate data and check bits alike
            array_wr_lane <= ~data_stage.lane_write_n;
         end
      end
   end

   // Driver control: outputs only while a read word is up and output enable is low
   // asynchronous output enable; internal masking wins
   assign drive_allowed = read_drive && !output_enable_n && !sleep_request;
   assign data_lines_oe = drive_allowed;
   assign check_bit_lines_oe = drive_allowed;
   assign data_lines_out = read_word[pbsc_pkg::DATA_W-1:0];
   assign check_bit_lines_out = read_word[pbsc_pkg::WORD_W-1:pbsc_pkg::DATA_W];
   assign array_rd_addr = addr_stage.addr;
   // sleep passed to the array; contents preserved
   assign array_sleep = sleep_request;

   // Checks of the pipeline against the pins
   default clocking pbsc_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_step_counter: assert property (step_now |=> burst_count == $past(burst_count) + 2'h1)
      else $error("burst counter did not step");
   a_load_address: assert property (load_now |=> addr_stage.addr == $past(addr_in) && burst_count == 2'h0)
      else $error("start address not loaded");
   a_stall_freeze: assert property (!edge_ok |=> $stable(addr_stage) && $stable(data_stage) && !array_wr_en)
      else $error("state moved on an unrecognized edge");
   a_select_decode: assert property (load_now |=> addr_stage.valid == $past(selected_now))
      else $error("chip select decode wrong");
   a_oe_blocks: assert property (output_enable_n |-> !data_lines_oe && !check_bit_lines_oe)
      else $error("drivers on with output enable high");
   a_write_tristate: assert property (edge_ok && addr_stage.valid && addr_stage.write |=> !data_lines_oe)
      else $error("drivers on in write data cycle");
   a_deselect_tristate: assert property (edge_ok && !addr_stage.valid |=> !read_drive)
      else $error("drivers not off after deselect");
   a_read_word: assert property (edge_ok && addr_stage.valid && !addr_stage.write
      |=> data_lines_out == $past(array_rd_data[pbsc_pkg::DATA_W-1:0]) && read_drive)
      else $error("read word not presented");
   a_write_latch: assert property (edge_ok && data_stage.valid && data_stage.write
      |=> array_wr_en && array_wr_data == {$past(check_bit_lines_in), $past(data_lines_in)})
      else $error("write data not taken");
   a_burst_type: assert property (step_now |=> addr_stage.write == $past(addr_stage.write))
      else $error("access type changed in burst");
   a_sleep_quiet: assert property (sleep_request |=> !array_wr_en)
      else $error("write during sleep");
   a_burst_order: assert property (step_now |=> addr_stage.addr[1:0]
      == pbsc_burst_pos($past(burst_order), burst_start, burst_count))
      else $error("burst address out of order");

   c_read_burst: cover property (load_now && selected_now && write_n ##1 step_now ##1 step_now ##1 step_now);
   c_write_done: cover property (load_now && selected_now && !write_n ##1 edge_ok ##1 edge_ok ##1 array_wr_en);
   c_stall_read: cover property (load_now && selected_now && write_n ##1 !edge_ok [*2] ##1 edge_ok);
   c_read_after_write: cover property (array_wr_en && data_lines_oe);
endmodule : pbsc_control

// ===== tb/pbsc_array_model.sv
// Storage array model standing behind the burst memory control.
// Assumes addresses below 256; the read answers combinationally, as the control expects.
module pbsc_array_model (
   // Clock
   input wire logic ref_clk,
   // Read and write ports of the array
   input wire logic [17:0] rd_addr,
   output logic [17:0] rd_data,
   input wire logic wr_en,
   input wire logic [17:0] wr_addr,
   input wire logic [17:0] wr_data,
   input wire logic [1:0] wr_lane
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] mem [256];
   // A lane is one data byte plus its check bit
   wire logic [17:0] wmask = {wr_lane, {8{wr_lane[1]}}, {8{wr_lane[0]}}};
   // Each word starts as a pattern of its own address, so a stale read shows
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = {2'h2, 8'(~i), 8'(i)};
   end
   assign rd_data = mem[rd_addr[7:0]];
   // Only enabled lanes change
   always @(posedge ref_clk)
      if (wr_en)
         mem[wr_addr[7:0]] <= (mem[wr_addr[7:0]] & ~wmask) | (wr_data & wmask);
endmodule : pbsc_array_model

// ===== tb/tb_top.sv
// Self-checking bench for the burst memory control; the bench plays the memory controller.
// Assumes the package, the control and the array model are compiled ahead of it.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [2:0] OFF = 3'h5;
   logic ref_clk, rst_n, step, wn, oen, slp, cqn, strap, dq_oe, cb_oe, wr_en, asleep;
   logic [2:0] cs;
   logic [1:0] bw, lane, cb_o;
   logic [15:0] dq_o;
   logic [17:0] a, drv, rd_a, rd_d, wr_a, wr_d;
   int num_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   // Shared lines: the device wins while it drives, else the bench value
   wire logic [17:0] line = {cb_oe ? cb_o : drv[17:16], dq_oe ? dq_o : drv[15:0]};
   pbsc_control uut (.ref_clk, .rst_n, .addr_in(a), .burst_step_or_load(step), .clock_qualify_n(cqn),
      .chip_select_low_first(cs[2]), .chip_select_high_second(cs[1]), .chip_select_low_third(cs[0]),
      .write_n(wn), .byte_lane_write_n(bw), .output_enable_n(oen), .sleep_request(slp),
      .burst_order_strap(strap), .data_lines_in(line[15:0]), .data_lines_out(dq_o), .data_lines_oe(dq_oe),
      .check_bit_lines_in(line[17:16]), .check_bit_lines_out(cb_o), .check_bit_lines_oe(cb_oe),
      .array_rd_addr(rd_a), .array_rd_data(rd_d), .array_wr_en(wr_en), .array_wr_addr(wr_a),
      .array_wr_data(wr_d), .array_wr_lane(lane), .array_sleep(asleep));
   pbsc_array_model mem (.ref_clk, .rd_addr(rd_a), .rd_data(rd_d), .wr_en, .wr_addr(wr_a),
      .wr_data(wr_d), .wr_lane(lane));
   // 200 MHz clock
   initial
   begin
      ref_clk = 1'h0;
      forever
         #2.5 ref_clk = ~ref_clk;
   end
   task chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task end_sim();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   // Cycle ceiling; the whole sequence needs about fifty cycles
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 1000)
      begin
         num_errors++;
         end_sim();
      end
   end
   // Present one access at an edge; the control samples it at the next edge
   task put(input logic s, input logic [2:0] c, input logic w, input logic [17:0] ad, input logic [1:0] b,
      input logic [17:0] d);
      @(posedge ref_clk);
      step <= s;
      cs <= c;
      wn <= w;
      a <= ad;
      bw <= b;
      drv <= d;
   endtask : put
   task t_write(input logic [17:0] ad, input logic [1:0] b, input logic [17:0] d);
      // Lane enables travel with the address edge of the write
      put(1'h0, SEL, 1'h0, ad, b, ~drv);
      put(1'h0, OFF, 1'h1, 18'h00000, 2'h3, ~drv);
      put(1'h0, OFF, 1'h1, 18'h00000, 2'h3, d);
      #1 chk(dq_oe, 1'h0);
      put(1'h0, OFF, 1'h1, 18'h00000, 2'h3, ~d);
      #1 chk({wr_en, lane, wr_a}, {1'h1, ~b, ad});
      chk(wr_d, d);
      @(posedge ref_clk);
      #1 chk(wr_en, 1'h0);
   endtask : t_write
   task t_read(input logic [17:0] ad, input logic [2:0] des, input logic o, input logic [17:0] exp);
      put(1'h0, SEL, 1'h1, ad, 2'h3, ~drv);
      oen <= o;
      put(1'h0, des, 1'h1, 18'h00000, 2'h3, ~drv);
      #1 chk(dq_oe, 1'h0);
      put(1'h0, des, 1'h1, 18'h00000, 2'h3, ~drv);
      #1 chk({cb_o, dq_o}, exp);
      chk({dq_oe, cb_oe}, {~o, ~o});
      put(1'h0, des, 1'h1, 18'h00000, 2'h3, ~drv);
      #1 chk({dq_oe, cb_oe}, 2'h0);
   endtask : t_read
   task t_burst(input logic s, input logic [17:0] ad);
      logic [1:0] n;
      put(1'h0, OFF, 1'h1, 18'h00000, 2'h3, ~drv);
      strap <= s;
      put(1'h0, SEL, 1'h1, ad, 2'h3, ~drv);
      // Steps carry a write level and a stray address, both to be ignored
      for (int k = 0; k < 5; k++)
      begin
         put(1'h1, OFF, 1'h0, ~ad, 2'h0, ~drv);
         n = s ? ad[1:0] ^ 2'(k) : ad[1:0] + 2'(k);
         #1 chk({wr_en, rd_a}, {1'h0, ad[17:2], n});
      end
   endtask : t_burst
   task t_freeze(input logic z, input logic [17:0] ad, input logic [17:0] exp);
      // Deselect first so no earlier read word is up during the stall
      put(1'h0, OFF, 1'h1, 18'h00000, 2'h3, ~drv);
      put(1'h0, SEL, 1'h1, ad, 2'h3, ~drv);
      put(1'h0, OFF, 1'h1, 18'h00000, 2'h3, ~drv);
      slp <= z;
      cqn <= ~z;
      #1 chk(asleep, z);
      @(posedge ref_clk);
      slp <= 1'h0;
      cqn <= 1'h0;
      #1 chk(dq_oe, 1'h0);
      @(posedge ref_clk);
      #1 chk({dq_oe, cb_o, dq_o}, {1'h1, exp});
   endtask : t_freeze
   // Main sequence; sleep stays low outside the sleep scenario
   initial
   begin
      {step, wn, oen, slp, cqn, strap, cs, bw} = 11'h237;
      a = 18'h00000;
      drv = 18'h00000;
      rst_n = 1'h0;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'h1;
      t_write(18'h00012, 2'h2, 18'h1A55C);
      t_read(18'h00056, 3'h3, 1'h1, 18'h2A956);
      t_read(18'h00012, 3'h6, 1'h0, 18'h3ED5C);
      t_read(18'h00034, 3'h0, 1'h0, 18'h2CB34);
      t_burst(1'h0, 18'h00045);
      t_burst(1'h1, 18'h00045);
      t_freeze(1'h0, 18'h00021, 18'h2DE21);
      t_freeze(1'h1, 18'h00022, 18'h2DD22);
      end_sim();
   end
endmodule : tb_top
